// ===== pkg/acm_pkg.sv
// Types of the carrier modulation and sync block
package acm_pkg;
  typedef struct packed {
    logic [1:0]  marker;
    logic [13:0] sample;
  } acm_word_s;
  typedef struct packed {
    acm_word_s   w1;
    acm_word_s   w0;
  } acm_pair_s;
  typedef struct packed {
    logic [3:0]  op;
    logic [27:0] arg;
  } acm_instr_s;
  typedef enum logic [2:0] {
    ACM_IDLE, ACM_WAITCNT, ACM_WAITZERO, ACM_WAITDONE
  } acm_seq_e;
endpackage : acm_pkg

// ===== pkg/acm_regs.svh
// Register map and constants of the carrier modulation and sync block
`ifndef ACM_REGS_SVH
`define ACM_REGS_SVH
`define ACM_ADDR_CTRL        12'h000
`define ACM_ADDR_AMP         12'h004
`define ACM_ADDR_PHASE       12'h008
`define ACM_ADDR_FREQ_A      12'h00c
`define ACM_ADDR_FREQ_B      12'h010
`define ACM_ADDR_INSTR       12'h014
`define ACM_ADDR_STATUS      12'h018
`define ACM_ADDR_WAVE        12'h01c
`define ACM_ADDR_OSCSEL      12'h020
`define ACM_CTRL_MOD0        0
`define ACM_CTRL_MOD1        1
`define ACM_CTRL_MF          2
`define ACM_CTRL_RST         32'h0000_0000
`define ACM_AMP_RST          32'h4000_4000
`define ACM_PHASE_RST        32'h0000_0000
`define ACM_FREQ_RST         32'h0000_0000
`define ACM_OSCSEL_RST       32'h0000_0000
`define ACM_OP_NOP           4'h0
`define ACM_OP_WAIT          4'h1
`define ACM_OP_WAIT_ZERO     4'h2
`define ACM_OP_PLAY          4'h3
`define ACM_OP_WAIT_DONE     4'h4
`define ACM_OP_TRIG          4'h5
`define ACM_CH_A             4'h4
`define ACM_CH_B             4'h8
`define ACM_SEQ_PERIOD_PS    4440
`define ACM_FIFO_DEPTH       32
`define ACM_FIFO_AW          5
`define ACM_AMP_SHIFT        14
`endif

// ===== rtl/acm_core.sv
// Sequencer, carrier oscillators and modulating output stage
//
// Chosen here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
// How it works
// RULE_01 - Carrier wait stalls the sequencer until selected channel phase wraps through zero; code waits on accumulator wrap, not offset phase.
// RULE_02 - Generic wait stalls for its argument in sequencer clock periods.
// RULE_03 - Modulation mode multiplies each envelope sample by its carrier amplitude.
// RULE_04 - Output one uses channel 4 carrier, output two channel 8.
// RULE_05 - Oscillators run always, whether playback is active or not.
// RULE_06 - Play starts both waveform outputs in the same cycle.
// RULE_07 - Each output has its own mode bit, applied live.
// RULE_08 - Shared oscillator allowed only with multi-frequency option; else independent.
// RULE_09 - Per-channel phase setting offsets the delivered carrier phase.
// RULE_10 - Amplitude and phase registers act live, stored waves untouched.
// RULE_11 - Play after carrier wait starts exactly on the zero phase; first sample uses oscillator one step past the wrap.
// RULE_12 - Waveform words hold 14 sample bits and 2 marker bits, aligned.
// RULE_13 - Trigger instruction drives four outputs, bit 0 to output one.
// RULE_14 - Wait-done holds further instructions until playback finishes.
// RULE_15 - Plain mode passes samples unmodulated, only amplitude scaled.
module acm_core
  import acm_pkg::*;
(
  input  wire logic        clock,      // 100 MHz clock
  input  wire logic        arst_n,     // Async reset, active low
  input  wire logic        psel,       // APB select
  input  wire logic        penable,    // APB enable
  input  wire logic        pwrite,     // APB direction
  input  wire logic [11:0] paddr,      // APB byte address
  input  wire logic [31:0] pwdata,     // APB write data
  output logic      [31:0] prdata,     // APB read data
  output logic             pready,     // APB ready
  output logic             pslverr,    // APB error
  output logic      [15:0] out0,       // Output one sample
  output logic      [15:0] out1,       // Output two sample
  output logic      [1:0]  mark0,      // Output one markers
  output logic      [1:0]  mark1,      // Output two markers
  output logic             out_valid,  // Samples are playing
  output logic      [3:0]  trig_out    // Trigger outputs
);
  `include "acm_regs.svh"

  //--------------------------------------------------------------
  // Register bus
  //--------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] amp_q;
  logic [31:0] phase_q;
  logic [31:0] freq_a_q;
  logic [31:0] freq_b_q;
  logic [31:0] oscsel_q;
  logic [31:0] prdata_q;
  logic        pslverr_q;
  logic        instr_full;
  logic        wave_full;
  logic        playing;
  acm_seq_e    state_q;
  acm_seq_e    state_d;

  wire acc      = psel && penable;
  // Read data and error are loaded in setup so they stand during access
  wire setup    = psel && !penable;
  wire rd_setup = setup && !pwrite;
  wire wr_acc   = acc && pwrite;
  wire rd_acc   = acc && !pwrite;
  wire a_ctrl   = paddr == `ACM_ADDR_CTRL;
  wire a_amp    = paddr == `ACM_ADDR_AMP;
  wire a_phase  = paddr == `ACM_ADDR_PHASE;
  wire a_fa     = paddr == `ACM_ADDR_FREQ_A;
  wire a_fb     = paddr == `ACM_ADDR_FREQ_B;
  wire a_instr  = paddr == `ACM_ADDR_INSTR;
  wire a_status = paddr == `ACM_ADDR_STATUS;
  wire a_wave   = paddr == `ACM_ADDR_WAVE;
  wire a_osc    = paddr == `ACM_ADDR_OSCSEL;
  wire mapped   = a_ctrl | a_amp | a_phase | a_fa | a_fb | a_instr | a_status | a_wave | a_osc;
  wire instr_wr = wr_acc && a_instr && !instr_full;
  wire wave_wr  = wr_acc && a_wave && !wave_full;
  // Stall pushes into a full FIFO by holding pready low
  wire stall    = acc && pwrite && ((a_instr && instr_full) || (a_wave && wave_full));
  wire [31:0] status_w = {26'h0, playing, wave_full, instr_full, state_q};
  wire [31:0] rd_mux =
    a_ctrl   ? ctrl_q   :
    a_amp    ? amp_q    :
    a_phase  ? phase_q  :
    a_fa     ? freq_a_q :
    a_fb     ? freq_b_q :
    a_status ? status_w :
    a_osc    ? oscsel_q : 32'h0000_0000;

  assign pready  = !stall;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q   <= `ACM_CTRL_RST;
      amp_q    <= `ACM_AMP_RST;
      phase_q  <= `ACM_PHASE_RST;
      freq_a_q <= `ACM_FREQ_RST;
      freq_b_q <= `ACM_FREQ_RST;
      oscsel_q <= `ACM_OSCSEL_RST;
    end else if (wr_acc) begin
      if (a_ctrl)  ctrl_q   <= pwdata;  // [RULE_07]
      if (a_amp)   amp_q    <= pwdata;  // [RULE_10]
      if (a_phase) phase_q  <= pwdata;  // [RULE_09] [RULE_10]
      if (a_fa)    freq_a_q <= pwdata;
      if (a_fb)    freq_b_q <= pwdata;
      if (a_osc)   oscsel_q <= pwdata;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= rd_setup ? rd_mux : 32'h0000_0000;
      pslverr_q <= setup && !mapped;
    end
  end

  //--------------------------------------------------------------
  // Instruction and waveform FIFOs
  //--------------------------------------------------------------
  acm_instr_s instr;
  logic       instr_valid;
  logic       instr_pop;
  logic       instr_rdy;
  acm_pair_s  wave;
  logic       wave_valid;
  logic       wave_pop;
  logic       wave_rdy;

  assign instr_full = !instr_rdy;
  assign wave_full  = !wave_rdy;

  acm_fifo #(.WIDTH(32), .DEPTH(`ACM_FIFO_DEPTH), .AW(`ACM_FIFO_AW)) u_instr_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_data   (pwdata),
    .in_valid  (instr_wr),
    .in_ready  (instr_rdy),
    .out_data  (instr),
    .out_valid (instr_valid),
    .out_ready (instr_pop)
  );

  acm_fifo #(.WIDTH(32), .DEPTH(`ACM_FIFO_DEPTH), .AW(`ACM_FIFO_AW)) u_wave_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_data   (pwdata),
    .in_valid  (wave_wr),
    .in_ready  (wave_rdy),
    .out_data  (wave),
    .out_valid (wave_valid),
    .out_ready (wave_pop)
  );

  //--------------------------------------------------------------
  // Carrier oscillators
  //--------------------------------------------------------------
  logic [31:0] osc_a_q;
  logic [31:0] osc_b_q;
  logic [31:0] osc_a_d;
  logic [31:0] osc_b_d;
  logic        wrap_a;
  logic        wrap_b;

  assign osc_a_d = osc_a_q + freq_a_q;
  assign osc_b_d = osc_b_q + freq_b_q;
  assign wrap_a  = osc_a_d < osc_a_q;
  assign wrap_b  = osc_b_d < osc_b_q;

  // Free running, never gated by playback
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      osc_a_q <= 32'h0000_0000;
      osc_b_q <= 32'h0000_0000;
    end else begin
      osc_a_q <= osc_a_d;  // [RULE_05]
      osc_b_q <= osc_b_d;  // [RULE_05]
    end
  end

  // Channel 8 may follow oscillator A only with the multi-frequency option
  wire        share  = ctrl_q[`ACM_CTRL_MF] && oscsel_q[0];  // [RULE_08]
  wire [31:0] base_b = share ? osc_a_q : osc_b_q;             // [RULE_08]
  wire        wrapb  = share ? wrap_a : wrap_b;
  // Channel phases: 16-bit offsets added to the top of the accumulator
  wire [15:0] ph4    = osc_a_q[31:16] + phase_q[15:0];       // [RULE_09] [RULE_04]
  wire [15:0] ph8    = base_b[31:16] + phase_q[31:16];       // [RULE_09] [RULE_04]

  // Triangle carrier, signed 15 bits, zero at phase zero
  function automatic logic signed [15:0] carrier(input logic [15:0] ph);
    logic [15:0] t;
    t = ph[15] ? ~ph : ph;
    carrier = ph[14] ^ ph[15] ? $signed({2'b00, ~t[13:0]}) : $signed({2'b00, t[13:0]});
    if (ph[15]) carrier = -carrier;
  endfunction : carrier

  wire signed [15:0] car0 = carrier(ph4);  // [RULE_04]
  wire signed [15:0] car1 = carrier(ph8);  // [RULE_04]

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  logic [27:0] cnt_q;
  logic [27:0] play_q;
  logic [3:0]  trig_q;
  logic        zero_sel_b_q;

  wire op_ok      = instr_valid && state_q == ACM_IDLE;
  wire is_play    = op_ok && instr.op == `ACM_OP_PLAY;
  wire zero_hit   = zero_sel_b_q ? wrapb : wrap_a;  // [RULE_01]
  assign playing  = play_q != 28'h0;
  assign wave_pop = playing && wave_valid;

  always_comb begin
    state_d   = state_q;
    instr_pop = 1'b0;
    unique case (state_q)
      ACM_IDLE: begin
        if (instr_valid) begin
          if (instr.op == `ACM_OP_PLAY) begin
            instr_pop = !playing;
          end else begin
            instr_pop = 1'b1;
          end
          if (instr.op == `ACM_OP_WAIT && instr.arg != 28'h0) state_d = ACM_WAITCNT;  // [RULE_02]
          if (instr.op == `ACM_OP_WAIT_ZERO) state_d = ACM_WAITZERO;                  // [RULE_01]
          if (instr.op == `ACM_OP_WAIT_DONE) state_d = ACM_WAITDONE;                  // [RULE_14]
        end
      end
      ACM_WAITCNT:  if (cnt_q == 28'h1) state_d = ACM_IDLE;   // [RULE_02]
      ACM_WAITZERO: if (zero_hit) state_d = ACM_IDLE;         // [RULE_01] [RULE_11]
      ACM_WAITDONE: if (!playing) state_d = ACM_IDLE;         // [RULE_14]
      default:      state_d = ACM_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_q      <= ACM_IDLE;
      cnt_q        <= 28'h0;
      play_q       <= 28'h0;
      trig_q       <= 4'h0;
      zero_sel_b_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ACM_WAITCNT) cnt_q <= cnt_q - 28'h1;
      if (instr_pop && instr.op == `ACM_OP_WAIT) cnt_q <= instr.arg;
      if (instr_pop && instr.op == `ACM_OP_WAIT_ZERO) zero_sel_b_q <= instr.arg[3:0] == `ACM_CH_B;
      if (instr_pop && instr.op == `ACM_OP_TRIG) trig_q <= instr.arg[3:0];  // [RULE_13]
      if (is_play && instr_pop) play_q <= instr.arg;                         // [RULE_06] [RULE_11]
      else if (wave_pop) play_q <= play_q - 28'h1;
    end
  end

  //--------------------------------------------------------------
  // Output stage
  //--------------------------------------------------------------
  acm_word_s   s0;
  acm_word_s   s1;
  logic [15:0] out0_q;
  logic [15:0] out1_q;
  logic [1:0]  mark0_q;
  logic [1:0]  mark1_q;
  logic        vld_q;

  assign s0 = wave_pop ? wave.w0 : '0;  // [RULE_12]
  assign s1 = wave_pop ? wave.w1 : '0;  // [RULE_12]

  wire signed [15:0] env0 = {{2{s0.sample[13]}}, s0.sample};
  wire signed [15:0] env1 = {{2{s1.sample[13]}}, s1.sample};
  wire signed [31:0] m0   = env0 * car0;  // [RULE_03]
  wire signed [31:0] m1   = env1 * car1;  // [RULE_03]
  wire signed [15:0] e0   = ctrl_q[`ACM_CTRL_MOD0] ? m0[29:14] : env0;  // [RULE_07] [RULE_15]
  wire signed [15:0] e1   = ctrl_q[`ACM_CTRL_MOD1] ? m1[29:14] : env1;  // [RULE_07] [RULE_15]
  wire signed [31:0] g0   = e0 * $signed({1'b0, amp_q[14:0]});           // [RULE_10]
  wire signed [31:0] g1   = e1 * $signed({1'b0, amp_q[30:16]});          // [RULE_10]

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out0_q  <= 16'h0000;
      out1_q  <= 16'h0000;
      mark0_q <= 2'h0;
      mark1_q <= 2'h0;
      vld_q   <= 1'b0;
    end else begin
      out0_q  <= g0[29:14];    // [RULE_06]
      out1_q  <= g1[29:14];    // [RULE_06]
      mark0_q <= s0.marker;    // [RULE_12]
      mark1_q <= s1.marker;    // [RULE_12]
      vld_q   <= wave_pop;
    end
  end

  assign out0      = out0_q;
  assign out1      = out1_q;
  assign mark0     = mark0_q;
  assign mark1     = mark1_q;
  assign out_valid = vld_q;
  assign trig_out  = trig_q;
endmodule : acm_core

// ===== rtl/acm_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/10ps
module acm_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clock,    // System clock
  input  wire logic             arst_n,   // Async reset
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  input  wire logic             in_valid, // Write valid
  output logic                  in_ready, // Not full
  output logic      [WIDTH-1:0] out_data, // Read data
  output logic                  out_valid,// Not empty
  input  wire logic             out_ready // Read accept
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;
  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem[rd_q[AW-1:0]];
  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
endmodule : acm_fifo

// ===== verification/acm_core_props.sv
// Port-level assertions of the carrier modulation block
`timescale 1ns/10ps
`include "acm_regs.svh"
module acm_core_props (
  input wire logic        clock,     // System clock
  input wire logic        arst_n,    // Async reset
  input wire logic        psel,      // APB select
  input wire logic        penable,   // APB enable
  input wire logic        pwrite,    // APB direction
  input wire logic [11:0] paddr,     // APB address
  input wire logic [31:0] prdata,    // APB read data
  input wire logic        pready,    // APB ready
  input wire logic        pslverr,   // APB error
  input wire logic [15:0] out0,      // Output one
  input wire logic        out_valid, // Sample strobe
  input wire logic [3:0]  trig_out   // Triggers
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  wire acc = psel && penable && pready;
  wire rd  = acc && !pwrite;
  wire map = paddr <= 12'h020 && paddr[1:0] == 2'h0;
  wire wo  = paddr == `ACM_ADDR_INSTR || paddr == `ACM_ADDR_WAVE;
  logic amp_set_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) amp_set_q <= 1'b0;
    else if (acc && pwrite && paddr == `ACM_ADDR_AMP) amp_set_q <= 1'b1;
  end
  sequence s_stall;
    psel && penable && !pready;
  endsequence
  sequence s_amp_read;
    rd && paddr == `ACM_ADDR_AMP && !amp_set_q;
  endsequence
  a_err_unmapped: assert property (acc && !map |-> pslverr)
    else $error("no error after unmapped access");
  a_err_mapped: assert property (acc && map |-> !pslverr)
    else $error("error after mapped access");
  a_ready_push: assert property (!pready |-> psel && penable && pwrite && wo)
    else $error("ready low outside a push");
  a_stall_ends: assert property (s_stall |-> ##[1:1000] pready)
    else $error("push stall never ends");
  a_rdata_quiet: assert property (prdata != 32'h0 |-> rd)
    else $error("read data outside a read");
  a_wo_zero: assert property (rd && wo |-> prdata == 32'h0)
    else $error("write-only place reads nonzero");
  a_amp_reset: assert property (s_amp_read |-> prdata == `ACM_AMP_RST)
    else $error("gain reset value wrong");
  a_reset_quiet: assert property ($rose(arst_n) |-> trig_out == 4'h0 && !out_valid && out0 == 16'h0)
    else $error("outputs busy after reset");
endmodule : acm_core_props
bind acm_core acm_core_props u_props (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out0(out0),
  .out_valid(out_valid), .trig_out(trig_out));

// ===== verification/acm_sink_model.sv
// Sample sink at the output stage's far side
`timescale 1ns/10ps
module acm_sink_model (
  input wire logic        clock,    // System clock
  input wire logic [15:0] out0,     // Output one
  input wire logic [15:0] out1,     // Output two
  input wire logic [1:0]  mark0,    // Output one markers
  input wire logic [1:0]  mark1,    // Output two markers
  input wire logic        out_valid // Sample strobe
);
  logic [35:0] seen [$];
  always @(posedge clock) begin
    if (out_valid === 1'b1) seen.push_back({mark1, out1, mark0, out0});
  end
endmodule : acm_sink_model

// ===== verification/tb_awg_carrier_modulation_sync.sv
// Self-checking bench of the carrier modulation block
`timescale 1ns/10ps
`include "acm_regs.svh"
module tb_awg_carrier_modulation_sync;
  import acm_pkg::*;
  typedef struct {logic [11:0] a; logic w; logic [31:0] d; logic [31:0] x; logic e;} acm_row_s;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, out_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] out0, out1;
  logic [1:0]  mark0, mark1;
  logic [3:0]  trig_out;
  logic [13:0] s0, s1;
  int bad_count, checks, cyc;
  acm_row_s rows [16] = '{'{`ACM_ADDR_CTRL, 0, 0, 0, 0}, '{`ACM_ADDR_AMP, 0, 0, 32'h4000_4000, 0},
    '{`ACM_ADDR_PHASE, 0, 0, 0, 0}, '{`ACM_ADDR_FREQ_A, 0, 0, 0, 0}, '{`ACM_ADDR_FREQ_B, 0, 0, 0, 0},
    '{`ACM_ADDR_OSCSEL, 0, 0, 0, 0}, '{`ACM_ADDR_STATUS, 0, 0, 0, 0},
    '{`ACM_ADDR_PHASE, 1, 32'h4000_0000, 0, 0}, '{`ACM_ADDR_PHASE, 0, 0, 32'h4000_0000, 0},
    '{`ACM_ADDR_CTRL, 1, 7, 0, 0}, '{`ACM_ADDR_CTRL, 0, 0, 7, 0}, '{`ACM_ADDR_INSTR, 0, 0, 0, 0},
    '{`ACM_ADDR_WAVE, 0, 0, 0, 0}, '{12'h024, 0, 0, 0, 1}, '{12'h100, 1, 5, 0, 1}, '{`ACM_ADDR_CTRL, 1, 0, 0, 0}};
  acm_core dut_u (.clock(clock), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .out0(out0),
    .out1(out1), .mark0(mark0), .mark1(mark1), .out_valid(out_valid), .trig_out(trig_out));
  acm_sink_model sink_u (.clock(clock), .out0(out0), .out1(out1), .mark0(mark0), .mark1(mark1),
    .out_valid(out_valid));
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  task automatic fail(input string n);
    bad_count++;
    $display("mismatch %s expected progress seen timeout", n);
    finish_test();
  endtask : fail
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 2000);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 2000) fail("pready");
    @(posedge clock);
  endtask : apb
  task automatic ins(input logic [3:0] op, input logic [27:0] arg);
    apb(`ACM_ADDR_INSTR, 1'b1, {op, arg});
  endtask : ins
  task automatic wait_trig(input logic [3:0] x);
    cyc = 0;
    do begin
      @(negedge clock);
      cyc++;
    end while (trig_out !== x && cyc < 3000);
    if (cyc >= 3000) fail("trig_out");
  endtask : wait_trig
  function automatic logic [17:0] expw(input logic [1:0] m, input logic [13:0] s, input int g);
    return {m, 16'($signed({{2{s[13]}}, s}) >>> g)};
  endfunction : expw
  task finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    foreach (rows[i]) begin
      apb(rows[i].a, rows[i].w, rows[i].d);
      if (!rows[i].w) chk("rdata", rows[i].x, rd);
      chk("slverr", 32'(rows[i].e), 32'(err));
    end
    $display("test registers done");
    ins(`ACM_OP_WAIT, 28'd50);
    ins(`ACM_OP_TRIG, 28'h1);
    wait_trig(4'h1);
    chk("wait_len", 1, 32'(cyc + 3 >= 50 && cyc + 3 <= 70));
    $display("test wait done");
    apb(`ACM_ADDR_FREQ_A, 1'b1, 32'h0100_0000);
    apb(`ACM_ADDR_FREQ_B, 1'b1, 32'h0080_0000);
    for (int c = 4; c <= 8; c += 4) begin
      apb(`ACM_ADDR_WAVE, 1'b1, 32'h0010_0020);
      ins(`ACM_OP_WAIT_ZERO, 28'(c));
      ins(`ACM_OP_PLAY, 28'd1);
      ins(`ACM_OP_WAIT_DONE, 28'd0);
      ins(`ACM_OP_TRIG, 28'(c));
      wait_trig(4'(c));
      chk("zero_wait", 32'(c), 32'(trig_out));
    end
    $display("test zero wait done");
    for (int g = 0; g < 2; g++) begin
      apb(`ACM_ADDR_AMP, 1'b1, g ? 32'h2000_2000 : 32'h4000_4000);
      for (int i = 0; i < 32; i++) begin
        s0 = 14'h3ff0 + 14'(2 * i);
        s1 = 14'h0100 + 14'(2 * i);
        apb(`ACM_ADDR_WAVE, 1'b1, {~2'(i), s1, 2'(i), s0});
      end
      apb(`ACM_ADDR_STATUS, 1'b0, 32'h0);
      chk("wave_full", 32'h1, 32'(rd[4]));
      sink_u.seen.delete();
      ins(`ACM_OP_PLAY, 28'd32);
      ins(`ACM_OP_WAIT_DONE, 28'd0);
      ins(`ACM_OP_TRIG, g ? 28'h5 : 28'ha);
      wait_trig(g ? 4'h5 : 4'ha);
      chk("count", 32'd32, 32'(sink_u.seen.size()));
      for (int i = 0; i < 32; i++) begin
        s0 = 14'h3ff0 + 14'(2 * i);
        s1 = 14'h0100 + 14'(2 * i);
        chk("out0", 32'(expw(2'(i), s0, g)), 32'(sink_u.seen[i][17:0]));
        chk("out1", 32'(expw(~2'(i), s1, g)), 32'(sink_u.seen[i][35:18]));
      end
    end
    $display("test stream done");
    repeat (34) ins(`ACM_OP_WAIT, 28'd200);
    apb(`ACM_ADDR_STATUS, 1'b0, 32'h0);
    chk("instr_full", 32'h1, 32'(rd[3]));
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    apb(`ACM_ADDR_STATUS, 1'b0, 32'h0);
    chk("status", 32'h0, rd);
    chk("trig_rst", 32'h0, 32'(trig_out));
    $display("test stall and reset done");
    finish_test();
  end
endmodule : tb_awg_carrier_modulation_sync
